// [src/cdhc_card_detect_host_control.sv]
// Purpose: host-facing control of a smart card coupler: programming, status, interrupt
// Assumes: all pin inputs asynchronous to clk_i; 125 MHz clock
// Notes:   interrupt pin is open drain; oe high pulls it low

`timescale 1ns/10ps

module cdhc_card_detect_host_control #(
   parameter int FILTER_CYCLES = cdhc_pkg::FILTER_CYCLES
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_i,
   // host pins
   input  wire logic chip_select_n_i,
   input  wire logic program_select_n_i,
   input  wire logic mode_sel_lo_i,
   input  wire logic mode_sel_hi_i,
   input  wire logic converter_enable_i,
   input  wire logic card_reset_i,
   input  wire logic host_data_i,
   output logic      status_o,
   output logic      irq_n_o,
   output logic      irq_n_oe_o,
   // card side
   input  wire logic card_presence_in_i,
   output logic      card_clock_out_o,
   output logic      card_reset_o,
   output logic      card_supply_out_o,
   output logic      supply_class_o,
   // analog monitors
   input  wire logic battery_low_i,
   input  wire logic supply_low_i
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic rose(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction

   function automatic logic fell(input logic cur, input logic prev);
      return ~cur & prev;
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [cdhc_pkg::PIN_W-1:0] pins_raw;
   logic [cdhc_pkg::PIN_W-1:0] sync1_reg,  sync2_reg, sync3_reg;
   logic [cdhc_pkg::PIN_W-1:0] clean_reg,  clean_next;
   logic [cdhc_pkg::PIN_W-1:0] prev_reg;

   always_comb begin
      pins_raw                           = '0;
      pins_raw[cdhc_pkg::PIN_CS_N]       = chip_select_n_i;
      pins_raw[cdhc_pkg::PIN_PGM_N]      = program_select_n_i;
      pins_raw[cdhc_pkg::PIN_SEL_LO]     = mode_sel_lo_i;
      pins_raw[cdhc_pkg::PIN_SEL_HI]     = mode_sel_hi_i;
      pins_raw[cdhc_pkg::PIN_CONV_EN]    = converter_enable_i;
      pins_raw[cdhc_pkg::PIN_CRD_RST]    = card_reset_i;
      pins_raw[cdhc_pkg::PIN_DATA]       = host_data_i;
      pins_raw[cdhc_pkg::PIN_PRESENCE]   = card_presence_in_i;
      pins_raw[cdhc_pkg::PIN_BAT_LOW]    = battery_low_i;
      pins_raw[cdhc_pkg::PIN_VCC_LOW]    = supply_low_i;
      // a bit moves only once stages two and three agree
      clean_next = (sync2_reg & ~(sync2_reg ^ sync3_reg))
                 | (clean_reg &  (sync2_reg ^ sync3_reg));
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync1_reg <= cdhc_pkg::PIN_RESET_VAL;
         sync2_reg <= cdhc_pkg::PIN_RESET_VAL;
         sync3_reg <= cdhc_pkg::PIN_RESET_VAL;
         clean_reg <= cdhc_pkg::PIN_RESET_VAL;
         prev_reg  <= cdhc_pkg::PIN_RESET_VAL;
      end else begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         clean_reg <= clean_next;
         prev_reg  <= clean_reg;
      end
   end

   logic       cs_n, cs_fall, cs_rise;
   logic       pgm_n, conv_rise, conv_fall;
   logic [1:0] sel;
   logic       bat_rise, vcc_low;

   assign cs_n      = clean_reg[cdhc_pkg::PIN_CS_N];
   assign cs_fall   = fell(cs_n, prev_reg[cdhc_pkg::PIN_CS_N]);
   assign cs_rise   = rose(cs_n, prev_reg[cdhc_pkg::PIN_CS_N]);
   assign pgm_n     = clean_reg[cdhc_pkg::PIN_PGM_N];
   assign conv_rise = rose(clean_reg[cdhc_pkg::PIN_CONV_EN], prev_reg[cdhc_pkg::PIN_CONV_EN]);
   assign conv_fall = fell(clean_reg[cdhc_pkg::PIN_CONV_EN], prev_reg[cdhc_pkg::PIN_CONV_EN]);
   assign sel       = {clean_reg[cdhc_pkg::PIN_SEL_HI], clean_reg[cdhc_pkg::PIN_SEL_LO]};
   assign bat_rise  = rose(clean_reg[cdhc_pkg::PIN_BAT_LOW], prev_reg[cdhc_pkg::PIN_BAT_LOW]);
   assign vcc_low   = clean_reg[cdhc_pkg::PIN_VCC_LOW];

   // ---------------------------------------------------------------
   // presence filter
   // ---------------------------------------------------------------
   cdhc_debounce_if dbif ();

   logic polarity_reg, polarity_next;

   assign dbif.raw      = clean_reg[cdhc_pkg::PIN_PRESENCE];
   assign dbif.polarity = polarity_reg;

   cdhc_debounce #(
      .FILTER_CYCLES (FILTER_CYCLES)
   ) u_debounce (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .dbif    (dbif)
   );

   // ---------------------------------------------------------------
   // host access, configuration and interrupt
   // ---------------------------------------------------------------
   cdhc_pkg::cdhc_state_e state_reg, state_next;

   logic       class_reg,    class_next;
   logic       stop_en_reg,  stop_en_next;
   logic       stop_lvl_reg, stop_lvl_next;
   logic [1:0] div_reg,      div_next;
   logic       conv_on_reg,  conv_on_next;
   logic       crd_rst_reg,  crd_rst_next;
   logic       status_reg,   status_next;
   logic       pending_reg,  pending_next;
   logic       vcc_prev_reg, vcc_fault;
   logic       irq_set, irq_clear;

   // supply fault only counts while the converter runs
   assign vcc_fault = vcc_low & conv_on_reg;

   always_comb begin
      state_next    = state_reg;
      polarity_next = polarity_reg;
      class_next    = class_reg;
      stop_en_next  = stop_en_reg;
      stop_lvl_next = stop_lvl_reg;
      div_next      = div_reg;
      conv_on_next  = conv_on_reg;
      crd_rst_next  = crd_rst_reg;
      status_next   = status_reg;
      irq_clear     = 1'b0;

      case (state_reg)
         cdhc_pkg::ST_IDLE: begin
            // chip select high: every control input is ignored
            if (cs_fall) begin
               state_next = pgm_n ? cdhc_pkg::ST_NORMAL
                                  : cdhc_pkg::ST_PROGRAM;
            end
         end
         cdhc_pkg::ST_NORMAL: begin
            if (conv_rise) begin
               conv_on_next = 1'b1;
               irq_clear    = 1'b1;
            end else if (conv_fall) begin
               conv_on_next = 1'b0;
            end
            crd_rst_next = conv_on_reg & clean_reg[cdhc_pkg::PIN_CRD_RST];
            case (sel)
               cdhc_pkg::STS_CARD:    status_next = dbif.present;
               cdhc_pkg::STS_BATTERY: status_next = ~clean_reg[cdhc_pkg::PIN_BAT_LOW];
               cdhc_pkg::STS_SUPPLY:  status_next = ~vcc_fault;
               default:               status_next = status_reg;
            endcase
            if (cs_rise) begin
               state_next = cdhc_pkg::ST_IDLE;
               irq_clear  = 1'b1;
            end
         end
         cdhc_pkg::ST_PROGRAM: begin
            // mode already held; program select may return high
            if (cs_rise) begin
               state_next = cdhc_pkg::ST_IDLE;
               irq_clear  = 1'b1;
               // written regardless of converter state
               case (sel)
                  cdhc_pkg::PRG_SUPPLY_CLASS: begin
                     class_next = clean_reg[cdhc_pkg::PIN_DATA];
                  end
                  cdhc_pkg::PRG_DET_POLARITY: begin
                     polarity_next = clean_reg[cdhc_pkg::PIN_DATA];
                  end
                  cdhc_pkg::PRG_CLOCK_STOP: begin
                     stop_en_next  = clean_reg[cdhc_pkg::PIN_DATA];
                     stop_lvl_next = clean_reg[cdhc_pkg::PIN_CRD_RST];
                  end
                  default: begin
                     div_next = {clean_reg[cdhc_pkg::PIN_CRD_RST],
                                 clean_reg[cdhc_pkg::PIN_DATA]};
                  end
               endcase
            end
         end
         default: begin
            state_next = cdhc_pkg::ST_IDLE;
         end
      endcase

      if (!conv_on_next) begin
         crd_rst_next = 1'b0;
      end

      // set wins over a clear in the same cycle; pin level never read back
      irq_set      = dbif.changed | bat_rise | (vcc_fault & ~vcc_prev_reg);
      pending_next = irq_set | (pending_reg & ~irq_clear);
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg    <= cdhc_pkg::ST_IDLE;
         polarity_reg <= cdhc_pkg::RST_POLARITY;
         class_reg    <= cdhc_pkg::RST_CLASS;
         stop_en_reg  <= cdhc_pkg::RST_STOP_EN;
         stop_lvl_reg <= cdhc_pkg::RST_STOP_LVL;
         div_reg      <= cdhc_pkg::RST_CLOCK_DIV;
         conv_on_reg  <= 1'b0;
         crd_rst_reg  <= 1'b0;
         status_reg   <= 1'b0;
         pending_reg  <= 1'b0;
         vcc_prev_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         polarity_reg <= polarity_next;
         class_reg    <= class_next;
         stop_en_reg  <= stop_en_next;
         stop_lvl_reg <= stop_lvl_next;
         div_reg      <= div_next;
         conv_on_reg  <= conv_on_next;
         crd_rst_reg  <= crd_rst_next;
         status_reg   <= status_next;
         pending_reg  <= pending_next;
         vcc_prev_reg <= vcc_fault;
      end
   end

   // ---------------------------------------------------------------
   // card clock
   // ---------------------------------------------------------------
   logic [2:0] div_cnt_reg, div_cnt_next;
   logic       cclk_reg,    cclk_next;
   logic       tick;

   always_comb begin
      // divide by 2, 4, 8 or 16 of clk_i
      tick         = div_cnt_reg >= ((3'h1 << div_reg) - 3'h1);
      div_cnt_next = tick ? 3'h0 : div_cnt_reg + 3'h1;
      cclk_next    = cclk_reg;
      if (!conv_on_reg) begin
         cclk_next = 1'b0;
      end else if (stop_en_reg) begin
         cclk_next = stop_lvl_reg;
      end else if (tick) begin
         cclk_next = ~cclk_reg;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_cnt_reg <= 3'h0;
         cclk_reg    <= 1'b0;
      end else begin
         div_cnt_reg <= div_cnt_next;
         cclk_reg    <= cclk_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   logic irq_lvl_reg, irq_oe_reg;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_lvl_reg <= 1'b1;
         irq_oe_reg  <= 1'b0;
      end else begin
         irq_lvl_reg <= ~pending_next;
         irq_oe_reg  <= pending_next;
      end
   end

   assign status_o          = status_reg;
   assign irq_n_o           = irq_lvl_reg;
   assign irq_n_oe_o        = irq_oe_reg;
   assign card_clock_out_o  = cclk_reg;
   assign card_reset_o      = crd_rst_reg;
   assign card_supply_out_o = conv_on_reg;
   assign supply_class_o    = class_reg;

endmodule // cdhc_card_detect_host_control

// [src/cdhc_pkg.sv]
// Purpose: shared constants and types of the card detect and host control block
// Assumes: 125 MHz system clock
// Notes:   every offset, code and timing count lives here, with the pin, setting and filter-level reset values

package cdhc_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_FREQ_MHZ   = 125;
   localparam int FILTER_TIME_US = 50;
   // least time, exact here: 50 us * 125 MHz = 6250 cycles
   localparam int FILTER_CYCLES  = FILTER_TIME_US * CLK_FREQ_MHZ;

   // ---------------------------------------------------------------
   // pin sample vector positions
   // ---------------------------------------------------------------
   localparam int PIN_W        = 10;
   localparam int PIN_CS_N     = 0;
   localparam int PIN_PGM_N    = 1;
   localparam int PIN_SEL_LO   = 2;
   localparam int PIN_SEL_HI   = 3;
   localparam int PIN_CONV_EN  = 4;
   localparam int PIN_CRD_RST  = 5;
   localparam int PIN_DATA     = 6;
   localparam int PIN_PRESENCE = 7;
   localparam int PIN_BAT_LOW  = 8;
   localparam int PIN_VCC_LOW  = 9;
   localparam logic [9:0] PIN_RESET_VAL = 10'h083;

   // ---------------------------------------------------------------
   // programming targets, chosen by {mode_sel_hi, mode_sel_lo}
   // ---------------------------------------------------------------
   localparam logic [1:0] PRG_SUPPLY_CLASS = 2'h0;
   localparam logic [1:0] PRG_DET_POLARITY = 2'h1;
   localparam logic [1:0] PRG_CLOCK_STOP   = 2'h2;
   localparam logic [1:0] PRG_CLOCK_DIV    = 2'h3;

   // ---------------------------------------------------------------
   // status selections
   // ---------------------------------------------------------------
   localparam logic [1:0] STS_CARD    = 2'h0;
   localparam logic [1:0] STS_BATTERY = 2'h1;
   localparam logic [1:0] STS_SUPPLY  = 2'h2;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic       RST_POLARITY  = 1'b0;  // normally open, falling edge = insert
   localparam logic       RST_CLASS     = 1'b0;  // lower card voltage
   localparam logic       RST_STOP_EN   = 1'b0;
   localparam logic       RST_STOP_LVL  = 1'b0;
   localparam logic [1:0] RST_CLOCK_DIV = 2'h0;
   localparam logic       RST_RAW_LEVEL = 1'b1;  // open switch idles high

   // ---------------------------------------------------------------
   // host access states, gray along idle -> normal -> program
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_NORMAL  = 2'b01,
      ST_PROGRAM = 2'b11
   } cdhc_state_e;

endpackage

// [src/cdhc_debounce_if.sv]
// Purpose: carrier between the controller and the presence filter
// Assumes: one clock domain
// Notes:   raw is already synchronised

`timescale 1ns/10ps

interface cdhc_debounce_if;
   logic raw;
   logic polarity;
   logic present;
   logic changed;

   modport filt (input raw, input polarity, output present, output changed);
   modport ctrl (output raw, output polarity, input present, input changed);
endinterface

// [src/cdhc_debounce.sv]
// Purpose: presence switch filter with programmable polarity
// Assumes: raw input already synchronised to clk_i
// Notes:   changed is a one-cycle pulse on every accepted state change

`timescale 1ns/10ps

module cdhc_debounce #(
   parameter int FILTER_CYCLES = cdhc_pkg::FILTER_CYCLES
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // filter side
   cdhc_debounce_if.filt    dbif
);

   localparam int CNT_W = $clog2(FILTER_CYCLES + 1);

   logic             accepted_reg, accepted_next;
   logic [CNT_W-1:0] count_reg,    count_next;
   logic             present_reg,  present_next;
   logic             changed_reg,  changed_next;

   // ---------------------------------------------------------------
   // filter
   // ---------------------------------------------------------------
   always_comb begin
      accepted_next = accepted_reg;
      count_next    = count_reg;
      if (dbif.raw == accepted_reg) begin
         count_next = '0;
      end else if (count_reg == CNT_W'(FILTER_CYCLES - 1)) begin
         accepted_next = dbif.raw;
         count_next    = '0;
      end else begin
         count_next = count_reg + CNT_W'(1);
      end
      // polarity decides which level means card present
      present_next = dbif.polarity ? accepted_next : ~accepted_next;
      changed_next = present_next != present_reg;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         accepted_reg <= cdhc_pkg::RST_RAW_LEVEL;
         count_reg    <= '0;
         present_reg  <= 1'b0;
         changed_reg  <= 1'b0;
      end else begin
         accepted_reg <= accepted_next;
         count_reg    <= count_next;
         present_reg  <= present_next;
         changed_reg  <= changed_next;
      end
   end

   assign dbif.present = present_reg;
   assign dbif.changed = changed_reg;

endmodule // cdhc_debounce

// [bench/cdhc_chk_sva.sv]
// Purpose: port-level checks of the card detect host control block
// Assumes: pin effects land 5..6 clocks after the pin moves
// Notes:   counters track how long presence and the chip select, battery, supply and converter group have stayed quiet, and chip select high

`timescale 1ns/10ps

module cdhc_chk_sva #(
   parameter int FILTER_CYCLES = cdhc_pkg::FILTER_CYCLES
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_i,
   // watched pins
   input  wire logic chip_select_n_i,
   input  wire logic program_select_n_i,
   input  wire logic converter_enable_i,
   input  wire logic card_presence_in_i,
   input  wire logic battery_low_i,
   input  wire logic supply_low_i,
   input  wire logic status_o,
   input  wire logic irq_n_o,
   input  wire logic irq_n_oe_o,
   input  wire logic card_supply_out_o,
   input  wire logic supply_class_o
);
   // ------
   // quiet counters
   // ------
   int   pres_cnt;
   int   oth_cnt;
   int   hi_cnt;
   logic prog_acc;

   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pres_cnt <= 0;
         oth_cnt  <= 0;
         hi_cnt   <= 0;
         prog_acc <= 1'h0;
      end else begin
         pres_cnt <= $changed(card_presence_in_i) ? 0 : pres_cnt + 1;
         oth_cnt  <= $changed({chip_select_n_i, battery_low_i, supply_low_i,
                               converter_enable_i}) ? 0 : oth_cnt + 1;
         hi_cnt   <= chip_select_n_i ? hi_cnt + 1 : 0;
         if ($fell(chip_select_n_i))
            prog_acc <= !program_select_n_i;
      end
   end

   // ------
   // assertions
   // ------
   reset_vals_a: assert property (
      $fell(reset_i) |-> !status_o && irq_n_o && !irq_n_oe_o && !card_supply_out_o
                         && !supply_class_o) else $error("outputs not at reset values");
   irq_release_a: assert property (
      $rose(chip_select_n_i) && !prog_acc |-> ##[4:8] (irq_n_o && !irq_n_oe_o))
      else $error("interrupt not released after chip select rise");
   irq_hold_a: assert property (
      irq_n_oe_o && hi_cnt >= 8 |=> irq_n_oe_o && !irq_n_o)
      else $error("pending interrupt dropped while deselected");
   battery_raise_a: assert property (
      $rose(battery_low_i) && hi_cnt >= 8 |-> ##[3:8] irq_n_oe_o)
      else $error("battery fault did not raise interrupt");
   irq_cause_a: assert property (
      $rose(irq_n_oe_o) |-> pres_cnt >= FILTER_CYCLES || oth_cnt <= 10)
      else $error("interrupt raised before presence filter ran out");
   cs_high_hold_a: assert property (
      hi_cnt >= 8 |-> $stable(status_o) && $stable(card_supply_out_o)
                      && $stable(supply_class_o)) else $error("output moved while deselected");
   conv_release_a: assert property (
      hi_cnt == 0 && !prog_acc && $rose(converter_enable_i) && !supply_low_i
      |-> ##[3:8] (card_supply_out_o && !irq_n_oe_o)) else $error("converter rise ignored");
   prog_hold_a: assert property (
      prog_acc && !chip_select_n_i |-> $stable(status_o) && $stable(card_supply_out_o))
      else $error("status or supply moved in programming access");
endmodule // cdhc_chk_sva

bind cdhc_card_detect_host_control cdhc_chk_sva #(.FILTER_CYCLES(FILTER_CYCLES)) chk (
   .clk_i, .reset_i, .chip_select_n_i, .program_select_n_i, .converter_enable_i,
   .card_presence_in_i, .battery_low_i, .supply_low_i, .status_o, .irq_n_o, .irq_n_oe_o,
   .card_supply_out_o, .supply_class_o);

// [bench/cdhc_host_model.sv]
// Purpose: host microcontroller model driving chip select and mode pins
// Assumes: pins move by non-blocking assignment at the rising edge
// Notes:   deselected mode select, card reset and data pins are scrambled, the block must ignore them

`timescale 1ns/10ps

module cdhc_host_model (
   // clock
   input  wire logic clk_i,
   // host pins
   output logic      cs_n_o,
   output logic      pgm_n_o,
   output logic      sel_lo_o,
   output logic      sel_hi_o,
   output logic      conv_en_o,
   output logic      rst_o,
   output logic      data_o,
   input  wire logic status_i
);
   initial begin
      {cs_n_o, pgm_n_o} = 2'h3;
      {sel_hi_o, sel_lo_o, conv_en_o, rst_o, data_o} = 5'h00;
   end

   // one chip select cycle; a read also acknowledges
   task automatic access(input logic pgm_n, input logic [1:0] sel, input logic rst,
                         input logic dat, input logic conv, output logic sts);
      @(posedge clk_i);
      cs_n_o               <= 1'h0;
      pgm_n_o              <= pgm_n;
      {sel_hi_o, sel_lo_o} <= sel;
      {rst_o, data_o}      <= {rst, dat};
      repeat (8) @(posedge clk_i);
      pgm_n_o   <= 1'h1;
      conv_en_o <= conv;
      repeat (8) @(posedge clk_i);
      sts = status_i;
      cs_n_o <= 1'h1;
      @(posedge clk_i);
      {sel_hi_o, sel_lo_o, rst_o, data_o} <= ~{sel, rst, dat};
      repeat (8) @(posedge clk_i);
   endtask
endmodule // cdhc_host_model

// [bench/testbench.sv]
// Purpose: self-checking bench of the card detect host control block
// Assumes: filter shortened to 20 clocks
// Notes:   status table first, then bounce, polarity, clock stop, class, reset

`timescale 1ns/10ps

module testbench;
   localparam int FILT = 20;
   typedef struct packed {
      logic [1:0] sel;
      logic       pres;
      logic       bat;
      logic       sup;
      logic       conv;
      logic       irq_n;
      logic       exp;
   } cdhc_row_s;
   logic clk_i, reset_i, pres, bat, sup, sts, a;
   logic status_o, irq_n_o, irq_n_oe_o, clk_o, rst_o, sup_o, class_o;
   logic cs_n, pgm_n, sel_lo, sel_hi, conv, crst, dat;
   int   failures, num_checks;
   cdhc_row_s rows [7] = '{
      '{2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1},
      '{2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
      '{2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1},
      '{2'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0},
      '{2'h2, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1},
      '{2'h2, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1},
      '{2'h2, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0}};

   cdhc_host_model host (.clk_i, .cs_n_o(cs_n), .pgm_n_o(pgm_n), .sel_lo_o(sel_lo),
      .sel_hi_o(sel_hi), .conv_en_o(conv), .rst_o(crst), .data_o(dat), .status_i(status_o));

   cdhc_card_detect_host_control #(.FILTER_CYCLES(FILT)) dut (.clk_i, .reset_i,
      .chip_select_n_i(cs_n), .program_select_n_i(pgm_n), .mode_sel_lo_i(sel_lo),
      .mode_sel_hi_i(sel_hi), .converter_enable_i(conv), .card_reset_i(crst),
      .host_data_i(dat), .status_o, .irq_n_o, .irq_n_oe_o, .card_presence_in_i(pres),
      .card_clock_out_o(clk_o), .card_reset_o(rst_o), .card_supply_out_o(sup_o),
      .supply_class_o(class_o), .battery_low_i(bat), .supply_low_i(sup));

   // ------
   // checking and closing
   // ------
   task automatic check_bit(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic check_outs(input logic [6:0] exp);
      num_checks++;
      if ({status_o, irq_n_o, irq_n_oe_o, clk_o, rst_o, sup_o, class_o} !== exp) begin
         failures++;
         $display("BAD outputs expected %h seen %h", exp,
                  {status_o, irq_n_o, irq_n_oe_o, clk_o, rst_o, sup_o, class_o});
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // waits out the filter plus the pin path
   task automatic settle_filter;
      repeat (FILT + 20) @(posedge clk_i);
      #1;
   endtask

   initial begin
      clk_i = 1'h0;
      forever #4 clk_i = ~clk_i;
   end

   // a hang costs far more than the roughly 1000 clocks the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      give_verdict;
   end

   // ------
   // main sequence
   // ------
   initial begin
      {pres, bat, sup} = 3'h4;
      reset_i          = 1'h1;
      failures         = 0;
      num_checks       = 0;
      repeat (6) @(posedge clk_i);
      reset_i <= 1'h0;
      repeat (5) @(posedge clk_i);
      foreach (rows[i]) begin
         @(posedge clk_i);
         {pres, bat, sup} <= {rows[i].pres, rows[i].bat, rows[i].sup};
         settle_filter;
         check_bit("irq_n_o", rows[i].irq_n, irq_n_o);
         host.access(1'h1, rows[i].sel, 1'h0, 1'h0, rows[i].conv, sts);
         check_bit("status_o", rows[i].exp, sts);
         #1 check_bit("irq_n_o", 1'h1, irq_n_o);
      end
      // bounces shorter than the filter
      for (int k = 0; k < 5; k++) begin
         @(posedge clk_i);
         pres <= ~pres;
         repeat (14) @(posedge clk_i);
      end
      #1 check_bit("irq_n_o", 1'h1, irq_n_o);
      settle_filter;
      check_bit("irq_n_o", 1'h0, irq_n_o);
      host.access(1'h1, 2'h0, 1'h0, 1'h0, 1'h1, sts);
      check_bit("status_o", 1'h1, sts);
      // rising edge now means insertion
      host.access(1'h0, 2'h1, 1'h0, 1'h1, 1'h1, sts);
      host.access(1'h1, 2'h0, 1'h0, 1'h0, 1'h1, sts);
      check_bit("status_o", 1'h0, sts);
      @(posedge clk_i);
      pres <= 1'h1;
      settle_filter;
      check_bit("irq_n_o", 1'h0, irq_n_o);
      host.access(1'h1, 2'h0, 1'h0, 1'h0, 1'h1, sts);
      check_bit("status_o", 1'h1, sts);
      // clock stop at both levels, then free running
      for (int l = 0; l < 2; l++) begin
         host.access(1'h0, 2'h2, l[0], 1'h1, 1'h1, sts);
         repeat (3) @(posedge clk_i);
         #1 check_bit("card_clock_out_o", l[0], clk_o);
      end
      host.access(1'h0, 2'h2, 1'h0, 1'h0, 1'h1, sts);
      #1 a = clk_o;
      @(posedge clk_i);
      #1 check_bit("card_clock_out_o", ~a, clk_o);
      // divide by four: the level flips once every two clocks
      host.access(1'h0, 2'h3, 1'h0, 1'h1, 1'h1, sts);
      #1 a = clk_o;
      repeat (2) @(posedge clk_i);
      #1 check_bit("card_clock_out_o", ~a, clk_o);
      // supply class written while the converter runs
      for (int c = 1; c >= 0; c--) begin
         host.access(1'h0, 2'h0, 1'h0, c[0], 1'h1, sts);
         check_bit("card_supply_out_o", 1'h1, sup_o);
         check_bit("supply_class_o", c[0], class_o);
      end
      // card reset follows its pin in a normal access and is kept once deselected
      host.access(1'h1, 2'h0, 1'h1, 1'h0, 1'h1, sts);
      check_bit("card_reset_o", 1'h1, rst_o);
      // second reset in mid-run; polarity must come back
      @(posedge clk_i);
      reset_i <= 1'h1;
      repeat (6) @(posedge clk_i);
      #1 check_outs(7'h20);
      @(posedge clk_i);
      reset_i <= 1'h0;
      repeat (5) @(posedge clk_i);
      pres <= 1'h0;
      settle_filter;
      check_bit("irq_n_o", 1'h0, irq_n_o);
      host.access(1'h1, 2'h0, 1'h0, 1'h0, 1'h0, sts);
      check_bit("status_o", 1'h1, sts);
      // programming also lands with the converter off
      host.access(1'h0, 2'h0, 1'h0, 1'h1, 1'h0, sts);
      check_bit("card_supply_out_o", 1'h0, sup_o);
      check_bit("supply_class_o", 1'h1, class_o);
      give_verdict;
   end
endmodule // testbench
